// ===== hdl/bsw_pkg.sv
// Constants and types for the backup supervisor watchdog logic
package bsw_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned WDOG_MS       = 800;
  localparam int unsigned RST_DELAY_MS  = 100;
  localparam int unsigned SEAL_MIN_MS   = 5;
  localparam int unsigned SEAL_MAX_MS   = 35;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned WDOG_CYC      = WDOG_MS * CYC_PER_MS;
  localparam int unsigned RST_DELAY_CYC = RST_DELAY_MS * CYC_PER_MS;
  localparam int unsigned SEAL_MIN_CYC  = SEAL_MIN_MS * CYC_PER_MS;
  localparam int unsigned SEAL_MAX_CYC  = SEAL_MAX_MS * CYC_PER_MS;
  localparam int unsigned CNT_W         = 25;
  localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 25'h1;
  localparam logic [1:0] SYNC_ZERO      = 2'h0;
  localparam int unsigned SELF_KICK_SHIFT = 3;
  localparam int unsigned SELF_KICK_MUL   = 7;

  // ------------------------------------------------------------
  // Freshness seal arming states (Gray along the arming path)
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BSW_SEAL_IDLE  = 2'h0,
    BSW_SEAL_ARMING = 2'h1,
    BSW_SEAL_ARMED  = 2'h3,
    BSW_SEAL_DONE   = 2'h2
  } bsw_seal_t;

  function automatic logic [CNT_W-1:0] bsw_sat_inc(input logic [CNT_W-1:0] v);
    bsw_sat_inc = (v == {CNT_W{1'b1}}) ? v : v + CNT_ONE;
  endfunction
endpackage

// ===== hdl/bsw_aux_cmp.sv
// Aux monitor comparator with hysteresis
`timescale 1ns/1ps
`default_nettype none
module bsw_aux_cmp
  import bsw_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic below_thr_i,
  input  wire logic above_hyst_i,
  output var  logic aux_fail_flag_n_o
);
  logic flag_reg;
  logic flag_next;

  // ------------------------------------------------------------
  // Hysteresis: fall on below, rise only past the upper trip
  // ------------------------------------------------------------
  always_comb
  begin
    flag_next = flag_reg;
    if (below_thr_i)
      flag_next = 1'b0;
    else if (above_hyst_i)
      flag_next = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  assign aux_fail_flag_n_o = flag_reg;

  chk_fail_low_below: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    below_thr_i |=> !aux_fail_flag_n_o) else $error("fail flag not low below threshold");
  chk_no_chatter: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!aux_fail_flag_n_o && !above_hyst_i) |=> !aux_fail_flag_n_o) else $error("fail flag rose early");
endmodule
`default_nettype wire

// ===== hdl/bsw_top.sv
// Backup supervisor: watchdog, reset, supply select and freshness seal
`timescale 1ns/1ps
`default_nettype none
module bsw_top
  import bsw_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES  = WDOG_CYC,
  parameter int unsigned RST_CYCLES   = RST_DELAY_CYC,
  parameter int unsigned SEAL_MIN_CYCLES = SEAL_MIN_CYC,
  parameter int unsigned SEAL_MAX_CYCLES = SEAL_MAX_CYC
)
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic main_above_thr_i,
  input  wire logic main_above_bat_i,
  input  wire logic bat_present_i,
  input  wire logic aux_below_thr_i,
  input  wire logic aux_above_hyst_i,
  input  wire logic aux_tied_main_i,
  input  wire logic aux_fail_pin_low_i,
  input  wire logic watchdog_kick_in_i,
  input  wire logic watchdog_kick_float_i,
  output var  logic watchdog_kick_in_o,
  output var  logic watchdog_kick_in_oe_b_o,
  output var  logic aux_fail_flag_n_o,
  output var  logic reset_n_o,
  output var  logic bat_select_o,
  output var  logic bat_connect_o,
  output var  logic seal_active_o
);
  logic [CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
  logic [CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
  logic [CNT_W-1:0] seal_cnt_reg, seal_cnt_next;
  logic             kick_prev_reg, kick_prev_next;
  logic             rst_n_reg, rst_n_next;
  logic             bat_sel_reg, bat_sel_next;
  logic             bat_con_reg, bat_con_next;
  logic             drv_reg, drv_next;
  logic             seal_reg, seal_next;
  logic             oe_b_reg, oe_b_next;
  bsw_seal_t        seal_st_reg, seal_st_next;
  logic             kick_edge, timeout, fault, setup_ok;

  // Self-kick point of a floating pin, seven eighths into the period
  localparam int unsigned SELF_KICK_CYC = (WDOG_CYCLES >> SELF_KICK_SHIFT) * SELF_KICK_MUL;

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  assign kick_edge = watchdog_kick_in_i ^ kick_prev_reg;
  assign timeout   = !watchdog_kick_float_i && (wd_cnt_reg >= WDOG_CYCLES[CNT_W-1:0] - CNT_ONE);

  always_comb
  begin
    kick_prev_next = watchdog_kick_in_i;
    drv_next       = 1'b0;
    oe_b_next      = !watchdog_kick_float_i;
    if (kick_edge || timeout || !rst_n_reg)
      wd_cnt_next = CNT_ZERO;
    else
      wd_cnt_next = wd_cnt_reg + CNT_ONE;
    // Floating input: hold low, one high pulse after 7/8 of the period
    if (watchdog_kick_float_i && wd_cnt_reg >= SELF_KICK_CYC[CNT_W-1:0] && !drv_reg)
      drv_next = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wd_cnt_reg    <= CNT_ZERO;
      kick_prev_reg <= 1'b0;
      drv_reg       <= 1'b0;
      oe_b_reg      <= 1'b1;
    end
    else
    begin
      wd_cnt_reg    <= wd_cnt_next;
      kick_prev_reg <= kick_prev_next;
      drv_reg       <= drv_next;
      oe_b_reg      <= oe_b_next;
    end
  end

  assign watchdog_kick_in_o     = drv_reg;
  // Weak drive only while floating; a driven pin wins outside
  assign watchdog_kick_in_oe_b_o = oe_b_reg;

  // ------------------------------------------------------------
  // Reset generator and supply select
  // ------------------------------------------------------------
  assign fault = timeout || !main_above_thr_i;

  always_comb
  begin
    rst_cnt_next = rst_cnt_reg;
    rst_n_next   = rst_n_reg;
    if (fault)
    begin
      rst_cnt_next = CNT_ZERO;
      rst_n_next   = 1'b0;
    end
    else if (!rst_n_reg)
    begin
      rst_cnt_next = bsw_sat_inc(rst_cnt_reg);
      if (rst_cnt_reg >= RST_CYCLES[CNT_W-1:0] - CNT_ONE)
        rst_n_next = 1'b1;
    end
    // Battery only when main below threshold and not above battery
    bat_sel_next = !main_above_thr_i && !main_above_bat_i;
    // Battery stays off while the arming outcome is still open, so it never
    // touches the output in the cycle the seal latches
    bat_con_next = bat_sel_next && !seal_reg && (seal_st_reg != BSW_SEAL_ARMING) && bat_present_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_cnt_reg <= CNT_ZERO;
      rst_n_reg   <= 1'b0;
      bat_sel_reg <= 1'b0;
      bat_con_reg <= 1'b0;
    end
    else
    begin
      rst_cnt_reg <= rst_cnt_next;
      rst_n_reg   <= rst_n_next;
      bat_sel_reg <= bat_sel_next;
      bat_con_reg <= bat_con_next;
    end
  end

  // ------------------------------------------------------------
  // Freshness seal
  // ------------------------------------------------------------
  assign setup_ok = bat_present_i && aux_fail_pin_low_i && aux_tied_main_i;

  always_comb
  begin
    seal_st_next  = seal_st_reg;
    seal_cnt_next = seal_cnt_reg;
    seal_next     = seal_reg;
    case (seal_st_reg)
      BSW_SEAL_IDLE:
        if (setup_ok && main_above_thr_i)
        begin
          seal_st_next  = BSW_SEAL_ARMING;
          seal_cnt_next = CNT_ONE;
        end
        else if (rst_n_reg)
          seal_st_next = BSW_SEAL_DONE; // Normal power-up, seal never armed
      BSW_SEAL_ARMING:
        if (!main_above_thr_i)
        begin
          // Window judged when main supply goes away
          if (seal_cnt_reg > SEAL_MIN_CYCLES[CNT_W-1:0] && seal_cnt_reg < SEAL_MAX_CYCLES[CNT_W-1:0])
          begin
            seal_st_next = BSW_SEAL_ARMED;
            seal_next    = 1'b1;
          end
          else
            seal_st_next = BSW_SEAL_IDLE;
        end
        else if (!setup_ok || seal_cnt_reg >= SEAL_MAX_CYCLES[CNT_W-1:0])
          seal_st_next = BSW_SEAL_DONE;
        else
          seal_cnt_next = bsw_sat_inc(seal_cnt_reg);
      BSW_SEAL_ARMED:
        if (rst_n_next && !rst_n_reg && main_above_thr_i)
        begin
          seal_st_next = BSW_SEAL_DONE;
          seal_next    = 1'b0;
        end
      BSW_SEAL_DONE:
        seal_next = 1'b0;
      default:
        seal_st_next = BSW_SEAL_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      seal_st_reg  <= BSW_SEAL_IDLE;
      seal_cnt_reg <= CNT_ZERO;
      seal_reg     <= 1'b0;
    end
    else
    begin
      seal_st_reg  <= seal_st_next;
      seal_cnt_reg <= seal_cnt_next;
      seal_reg     <= seal_next;
    end
  end

  assign reset_n_o     = rst_n_reg;
  assign bat_select_o  = bat_sel_reg;
  assign bat_connect_o = bat_con_reg;
  assign seal_active_o = seal_reg;

  bsw_aux_cmp u_bsw_aux_cmp
  (
    .clk_i             (clk_i),
    .rst_b_i           (rst_b_i),
    .below_thr_i       (aux_below_thr_i),
    .above_hyst_i      (aux_above_hyst_i),
    .aux_fail_flag_n_o (aux_fail_flag_n_o)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_seal_isolates: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    seal_active_o |-> !bat_connect_o) else $error("battery connected while sealed");
  chk_kick_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $changed(watchdog_kick_in_i) |=> wd_cnt_reg == CNT_ZERO) else $error("edge did not clear counter");
  chk_float_no_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (watchdog_kick_float_i && main_above_thr_i && reset_n_o) |=> reset_n_o) else $error("timeout while floating");
  chk_bat_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    1'b1 |=> bat_select_o == (!$past(main_above_thr_i) && !$past(main_above_bat_i))) else $error("bad select");
  chk_reset_on_fault: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !main_above_thr_i |=> !reset_n_o) else $error("reset not asserted");
  chk_timeout_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wd_cnt_reg == WDOG_CYCLES[CNT_W-1:0] - CNT_ONE && !watchdog_kick_float_i) |=> !reset_n_o) else $error("no timeout reset");
  chk_seal_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(reset_n_o) |=> !seal_active_o) else $error("seal kept after reset release");
  chk_pulse_single: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    watchdog_kick_in_o |=> !watchdog_kick_in_o) else $error("self pulse too long");

  cov_timeout: cover property (@(posedge clk_i) disable iff (!rst_b_i) timeout);
  cov_bat: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(bat_select_o));
  cov_seal: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(seal_active_o));
endmodule
`default_nettype wire

// ===== sim/bsw_cpu_model.sv
// Processor model that kicks the watchdog input
`timescale 1ns/1ps
`default_nettype none
module bsw_cpu_model
(
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] gap_i,
  output var  logic       kick_o
);
  logic [7:0] cnt_reg;
  initial cnt_reg = 8'h00;
  initial kick_o = 1'b0;
  // ------------------------------------------------------------
  // Kick pulse
  // ------------------------------------------------------------
  // Pin stays low most of the time to save input current
  // One low-high-low pulse per gap, well inside the period
  always @(negedge clk_i)
  begin
    kick_o  <= run_i && (cnt_reg == gap_i);
    cnt_reg <= (!run_i || cnt_reg == gap_i) ? 8'h00 : cnt_reg + 8'h01;
  end
endmodule
`default_nettype wire

// ===== sim/tb_bsw_top.sv
// Testbench for the backup supervisor top level
`timescale 1ns/1ps
`default_nettype none
module tb_bsw_top;
  import bsw_pkg::*;
  localparam int WD = 64;
  localparam int RC = 16;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic main_thr = 1'b0, main_bat = 1'b0, bat_pres = 1'b1, aux_below = 1'b0;
  logic aux_hyst = 1'b1, aux_tied = 1'b1, aux_gnd = 1'b1, kick_float = 1'b0;
  logic cpu_run = 1'b1, tb_kick = 1'b0, tb_hold = 1'b0, cpu_kick, kick_pin;
  logic watchdog_kick_in_o, watchdog_kick_in_oe_b_o, aux_fail_flag_n_o;
  logic reset_n_o, bat_select_o, bat_connect_o, seal_active_o;
  int failures = 0;
  int compares = 0;

  always #20 clk_i = ~clk_i;
  // Device drives the pin only while it floats; otherwise the processor owns it
  // The bench may also hold the pin low, overpowering the weak self-drive
  assign kick_pin = tb_hold ? 1'b0 : (watchdog_kick_in_oe_b_o === 1'b0) ? watchdog_kick_in_o : (cpu_kick ^ tb_kick);

  bsw_top #(.WDOG_CYCLES(WD), .RST_CYCLES(RC), .SEAL_MIN_CYCLES(8), .SEAL_MAX_CYCLES(40)) u_bsw_top
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .main_above_thr_i(main_thr), .main_above_bat_i(main_bat),
    .bat_present_i(bat_pres), .aux_below_thr_i(aux_below), .aux_above_hyst_i(aux_hyst),
    .aux_tied_main_i(aux_tied), .aux_fail_pin_low_i(aux_gnd), .watchdog_kick_in_i(kick_pin),
    .watchdog_kick_float_i(kick_float), .watchdog_kick_in_o(watchdog_kick_in_o),
    .watchdog_kick_in_oe_b_o(watchdog_kick_in_oe_b_o), .aux_fail_flag_n_o(aux_fail_flag_n_o),
    .reset_n_o(reset_n_o), .bat_select_o(bat_select_o), .bat_connect_o(bat_connect_o),
    .seal_active_o(seal_active_o)
  );
  bsw_cpu_model u_bsw_cpu_model (.clk_i(clk_i), .run_i(cpu_run), .gap_i(8'h28), .kick_o(cpu_kick));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Bounded wait for the reset output to reach a level
  task automatic wait_rst(input logic lvl, output int n);
    n = 0;
    while (reset_n_o !== lvl && n < 300)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_seal;
    int n;
    main_thr = 1'b1;
    main_bat = 1'b1;
    cyc(12);
    main_thr = 1'b0;
    main_bat = 1'b0;
    cyc(2);
    chk(seal_active_o === 1'b1, "seal not armed");
    chk(bat_select_o === 1'b1 && bat_connect_o === 1'b0, "sealed battery connected");
    aux_gnd = 1'b0;
    aux_tied = 1'b0;
    main_thr = 1'b1;
    main_bat = 1'b1;
    wait_rst(1'b1, n);
    chk(n >= RC && n <= RC + 3, "reset delay");
    chk(seal_active_o === 1'b0, "seal kept");
    $display("test seal done");
  endtask
  task automatic test_supply;
    int n;
    for (int i = 0; i < 4; i++)
    begin
      main_thr = i[1];
      main_bat = i[0];
      cyc(2);
      chk(bat_select_o === (i == 0), "source select");
      chk(bat_connect_o === (i == 0), "battery switch");
      chk(i > 1 || reset_n_o === 1'b0, "undervoltage reset");
    end
    wait_rst(1'b1, n);
    chk(n <= RC + 3, "reset release");
    $display("test supply done");
  endtask
  task automatic test_aux;
    aux_below = 1'b1;
    aux_hyst = 1'b0;
    cyc(2);
    chk(aux_fail_flag_n_o === 1'b0, "aux fail");
    aux_below = 1'b0;
    cyc(4);
    chk(aux_fail_flag_n_o === 1'b0, "aux chatter");
    aux_hyst = 1'b1;
    cyc(2);
    chk(aux_fail_flag_n_o === 1'b1, "aux recover");
    $display("test aux done");
  endtask
  task automatic test_timeout;
    int n;
    for (n = 0; n < 300; n++)
    begin
      @(negedge clk_i);
      chk(reset_n_o === 1'b1, "reset while kicked");
    end
    cpu_run = 1'b0;
    cyc(2);
    tb_kick = 1'b1;
    cyc(50);
    tb_kick = 1'b0;
    wait_rst(1'b0, n);
    chk(n >= WD - 1 && n <= WD + 8, "timeout count");
    cpu_run = 1'b1;
    wait_rst(1'b1, n);
    chk(n >= RC - 1 && n <= RC + 3, "timeout release");
    $display("test timeout done");
  endtask
  task automatic test_float;
    int t0, t1;
    cpu_run = 1'b0;
    kick_float = 1'b1;
    t0 = -1;
    t1 = -1;
    for (int i = 0; i < 300; i++)
    begin
      @(negedge clk_i);
      chk(reset_n_o === 1'b1, "timeout while floating");
      if (watchdog_kick_in_o === 1'b1)
      begin
        t0 = t1;
        t1 = i;
      end
    end
    chk(watchdog_kick_in_oe_b_o === 1'b0, "pin not driven");
    chk(t0 >= 0 && t1 - t0 >= WD * 7 / 8 - 2 && t1 - t0 <= WD * 7 / 8 + 4, "self kick");
    // No edges reach the counter now: it runs past the period, yet no reset
    tb_hold = 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge clk_i);
      chk(reset_n_o === 1'b1, "timeout on held floating pin");
    end
    tb_hold = 1'b0;
    $display("test float done");
  endtask
  task automatic test_reseal;
    cpu_run = 1'b1;
    kick_float = 1'b0;
    main_thr = 1'b0;
    main_bat = 1'b0;
    aux_gnd = 1'b1;
    aux_tied = 1'b1;
    rst_b_i = 1'b0;
    cyc(2);
    rst_b_i = 1'b1;
    chk(reset_n_o === 1'b0 && seal_active_o === 1'b0, "outputs in reset");
    // Main supply good for too short a time
    main_thr = 1'b1;
    main_bat = 1'b1;
    cyc(4);
    main_thr = 1'b0;
    main_bat = 1'b0;
    cyc(2);
    chk(seal_active_o === 1'b0, "seal armed too early");
    // Main supply good for too long a time
    main_thr = 1'b1;
    main_bat = 1'b1;
    cyc(45);
    chk(reset_n_o === 1'b1 && seal_active_o === 1'b0, "seal armed while held");
    main_thr = 1'b0;
    main_bat = 1'b0;
    cyc(2);
    chk(seal_active_o === 1'b0, "seal armed too late");
    chk(bat_connect_o === 1'b1, "battery after abandoned seal");
    $display("test reseal done");
  endtask

  initial
  begin
    #(40 * 4000);
    failures++;
    end_sim();
  end
  initial
  begin
    cyc(6);
    rst_b_i = 1'b1;
    test_seal();
    test_supply();
    test_aux();
    test_timeout();
    test_float();
    test_reseal();
    end_sim();
  end
endmodule
`default_nettype wire
